//--- pkg/cotr_consts.vh
// Operation
// [RULE1] each trim register keeps a 12-bit unsigned correction in bits 11-0
// [RULE2] core zero uses its second-input trim on second input, first on first
// [RULE3] core one uses one trim per input, matching the sampled input
// [RULE4] after reset each field holds factory trim; software reads and overwrites it
// [RULE5] software never writes trims while foreground calibration runs
// [RULE6] software never writes trims while both background enables are set
// [RULE7] offset cal on, background offset off: read only after foreground done
// [RULE8] both background enables set: read only while calibration is stopped
// [RULE9] core two uses its first-input trim while sampling the first input
// [RULE10] software writes zero to bits 15-12 and ignores their read value
//
// Purpose: constants of the core offset trim register bank
// Assumes: byte addresses as printed, one 16-bit register per pair of bytes
// Notes:   none
`ifndef COTR_CONSTS_VH
`define COTR_CONSTS_VH
`define COTR_ADDR_W        12
`define COTR_DATA_W        16
`define COTR_TRIM_W        12
`define COTR_TRIM_MSB      11
`define COTR_OFS_C0_IN1    12'h08A
`define COTR_OFS_C0_IN2    12'h08C
`define COTR_OFS_C1_IN1    12'h08E
`define COTR_OFS_C1_IN2    12'h090
`define COTR_OFS_C2_IN1    12'h092
`define COTR_OFS_STATUS    12'h0A0
`define COTR_STAT_WR_BLOCK 0
`define COTR_STAT_RD_OK    1
`define COTR_STAT_WR_ERR   2
`define COTR_STAT_RD_ERR   3
`define COTR_NUM_REGS      5
`endif

//--- design/cotr_regs.v
// Purpose: offset trim register bank with per-core, per-input trim selection
// Assumes: inputs synchronous to clock_i; factory trims are static inputs
// Notes:   access hazards are flagged in a status word, not blocked
//
// Added by the designer: the plain strobed port.
`timescale 1ns/1ps
`include "cotr_consts.vh"

module cotr_regs #(
  parameter NUM_REGS = `COTR_NUM_REGS
) (
  input  wire                             clock_i,          // 125 MHz clock
  input  wire                             srst_i,           // sync reset, active high
  input  wire [`COTR_ADDR_W-1:0]          addr_i,           // register byte address
  input  wire [`COTR_DATA_W-1:0]          wdata_i,          // write data
  input  wire                             wr_i,             // write strobe
  input  wire                             rd_i,             // read strobe
  output reg  [`COTR_DATA_W-1:0]          rdata_o,          // read data, cycle after rd_i
  input  wire [NUM_REGS*`COTR_TRIM_W-1:0] factory_trim_i,   // factory trims, one slot per register
  input  wire                             fg_cal_running_i, // foreground calibration underway
  input  wire                             bg_cal_en_i,      // background calibration enable
  input  wire                             bg_os_cal_en_i,   // background offset calibration enable
  input  wire                             os_cal_en_i,      // offset calibration enable
  input  wire                             foreground_done_flag_i,        // foreground done flag
  input  wire                             calibration_stopped_flag_i,    // calibration stopped flag
  input  wire                             c0_sel_in2_i,     // core zero samples second input
  input  wire                             c1_sel_in2_i,     // core one samples second input
  output reg  [`COTR_TRIM_W-1:0]          c0_trim_o,        // trim applied to core zero
  output reg  [`COTR_TRIM_W-1:0]          c1_trim_o,        // trim applied to core one
  output reg  [`COTR_TRIM_W-1:0]          c2_trim_o         // trim applied to core two
);

  // widths of the bus word and of the correction field
  localparam DATA_W     = `COTR_DATA_W;
  localparam TRIM_W     = `COTR_TRIM_W;
  localparam PAD_W      = DATA_W - TRIM_W;
  localparam STAT_PAD_W = DATA_W - 4;

  // slot order, shared by the bank and by factory_trim_i
  localparam IDX_C0_IN1 = 0;
  localparam IDX_C0_IN2 = 1;
  localparam IDX_C1_IN1 = 2;
  localparam IDX_C1_IN2 = 3;
  localparam IDX_C2_IN1 = 4;

  // address decode
  reg  [NUM_REGS-1:0]        hit;
  wire                       trim_hit;
  wire                       status_hit;
  wire [NUM_REGS-1:0]        wr_en;
  wire                       trim_wr;
  wire                       trim_rd;
  wire                       status_wr;
  wire                       status_rd;

  // calibration state as software sees it
  wire                       bg_os_active;
  wire                       fg_os_mode;
  wire                       wr_block;
  wire                       rd_ok;

  // sticky hazard flags
  wire                       wr_err_set;
  wire                       wr_err_clr;
  wire                       rd_err_set;
  wire                       rd_err_clr;
  reg                        wr_err_d;
  reg                        rd_err_d;
  reg                        wr_err_q;
  reg                        rd_err_q;

  // stored trims, flattened for the muxes
  wire [NUM_REGS*TRIM_W-1:0] trim_flat;
  wire [TRIM_W-1:0]          trim_c0_in1;
  wire [TRIM_W-1:0]          trim_c0_in2;
  wire [TRIM_W-1:0]          trim_c1_in1;
  wire [TRIM_W-1:0]          trim_c1_in2;
  wire [TRIM_W-1:0]          trim_c2_in1;

  // read path
  reg  [TRIM_W-1:0]          trim_rd_sel;
  wire [DATA_W-1:0]          status_word;
  reg  [DATA_W-1:0]          rdata_d;
  integer                    k;

  // applied trims
  reg  [TRIM_W-1:0]          c0_trim_d;
  reg  [TRIM_W-1:0]          c1_trim_d;
  reg  [TRIM_W-1:0]          c2_trim_d;

  // one-hot decode; odd byte addresses and gaps
  // match nothing, so they read zero and ignore writes
  always @* begin
    hit = {NUM_REGS{1'b0}};
    case (addr_i)
      `COTR_OFS_C0_IN1: hit[IDX_C0_IN1] = 1'b1;
      `COTR_OFS_C0_IN2: hit[IDX_C0_IN2] = 1'b1;
      `COTR_OFS_C1_IN1: hit[IDX_C1_IN1] = 1'b1;
      `COTR_OFS_C1_IN2: hit[IDX_C1_IN2] = 1'b1;
      `COTR_OFS_C2_IN1: hit[IDX_C2_IN1] = 1'b1;
      default:          hit = {NUM_REGS{1'b0}};
    endcase
  end

  assign trim_hit   = |hit;
  assign status_hit = (addr_i == `COTR_OFS_STATUS);

  // access kinds, one per strobe and target
  assign trim_wr   = wr_i & trim_hit;
  assign trim_rd   = rd_i & trim_hit;
  assign status_wr = wr_i & status_hit;
  assign status_rd = rd_i & status_hit;

  // writes land even in a hazard window;
  // the sticky flag tells software it broke the protocol
  assign wr_en = hit & {NUM_REGS{wr_i}};

  // [RULE6] [RULE8] background offset loop
  assign bg_os_active = bg_cal_en_i & bg_os_cal_en_i;

  // [RULE7] foreground offset mode
  assign fg_os_mode = os_cal_en_i & ~bg_os_cal_en_i;

  // [RULE5] [RULE6] write hazard window
  assign wr_block = fg_cal_running_i | bg_os_active;

  // [RULE7] [RULE8] read safety window
  // outside both modes the values are static, so reads are safe
  assign rd_ok = bg_os_active ? calibration_stopped_flag_i :
                 fg_os_mode   ? foreground_done_flag_i     : 1'b1;

  // hazard events and write-one clears
  assign wr_err_set = trim_wr & wr_block;
  assign rd_err_set = trim_rd & ~rd_ok;
  assign wr_err_clr = status_wr & wdata_i[`COTR_STAT_WR_ERR];
  assign rd_err_clr = status_wr & wdata_i[`COTR_STAT_RD_ERR];

  // a new hazard in the clearing cycle wins,
  // so software never loses an event it has not yet seen
  always @* begin
    wr_err_d = wr_err_q;
    if (wr_err_set) begin
      wr_err_d = 1'b1;
    end else if (wr_err_clr) begin
      wr_err_d = 1'b0;
    end
  end

  always @* begin
    rd_err_d = rd_err_q;
    if (rd_err_set) begin
      rd_err_d = 1'b1;
    end else if (rd_err_clr) begin
      rd_err_d = 1'b0;
    end
  end

  always @(posedge clock_i) begin
    if (srst_i) begin
      wr_err_q <= 1'b0;
      rd_err_q <= 1'b0;
    end else begin
      wr_err_q <= wr_err_d;
      rd_err_q <= rd_err_d;
    end
  end

  // one storage slot per register; the reserved
  // upper bits are not stored and read back as zero
  genvar g;
  generate
    for (g = 0; g < NUM_REGS; g = g + 1) begin : g_trim
      reg [TRIM_W-1:0] value_q;
      always @(posedge clock_i) begin
        // [RULE4] factory value at reset
        if (srst_i) begin
          value_q <= factory_trim_i[g*TRIM_W +: TRIM_W];
        // [RULE1] twelve-bit field only
        end else if (wr_en[g]) begin
          value_q <= wdata_i[TRIM_W-1:0];
        end
      end
      assign trim_flat[g*TRIM_W +: TRIM_W] = value_q;
    end
  endgenerate

  // named slots for the datapath muxes
  assign trim_c0_in1 = trim_flat[IDX_C0_IN1*TRIM_W +: TRIM_W];
  assign trim_c0_in2 = trim_flat[IDX_C0_IN2*TRIM_W +: TRIM_W];
  assign trim_c1_in1 = trim_flat[IDX_C1_IN1*TRIM_W +: TRIM_W];
  assign trim_c1_in2 = trim_flat[IDX_C1_IN2*TRIM_W +: TRIM_W];
  assign trim_c2_in1 = trim_flat[IDX_C2_IN1*TRIM_W +: TRIM_W];

  // [RULE4] read back stored slot
  always @* begin
    trim_rd_sel = {TRIM_W{1'b0}};
    for (k = 0; k < NUM_REGS; k = k + 1) begin
      if (hit[k]) begin
        trim_rd_sel = trim_flat[k*TRIM_W +: TRIM_W];
      end
    end
  end

  // live windows in the low bits, sticky errors above
  assign status_word = {{STAT_PAD_W{1'b0}}, rd_err_q, wr_err_q, rd_ok, wr_block};

  // read data stand one cycle only; idle cycles return zero
  always @* begin
    rdata_d = {DATA_W{1'b0}};
    if (trim_rd) begin
      rdata_d = {{PAD_W{1'b0}}, trim_rd_sel};
    end else if (status_rd) begin
      rdata_d = status_word;
    end
  end

  always @(posedge clock_i) begin
    if (srst_i) begin
      rdata_o <= {DATA_W{1'b0}};
    end else begin
      rdata_o <= rdata_d;
    end
  end

  // [RULE2] core zero input select
  always @* begin
    case (c0_sel_in2_i)
      1'b1:    c0_trim_d = trim_c0_in2;
      default: c0_trim_d = trim_c0_in1;
    endcase
  end

  // [RULE3] core one input select
  always @* begin
    case (c1_sel_in2_i)
      1'b1:    c1_trim_d = trim_c1_in2;
      default: c1_trim_d = trim_c1_in1;
    endcase
  end

  // [RULE9] core two first input
  // only the first-input slot of core two lives in this bank
  always @* begin
    c2_trim_d = trim_c2_in1;
  end

  // registered trims keep the datapath free of decode glitches,
  // at the cost of one cycle from select change to applied value
  always @(posedge clock_i) begin
    if (srst_i) begin
      c0_trim_o <= {TRIM_W{1'b0}};
    end else begin
      c0_trim_o <= c0_trim_d;
    end
  end

  always @(posedge clock_i) begin
    if (srst_i) begin
      c1_trim_o <= {TRIM_W{1'b0}};
    end else begin
      c1_trim_o <= c1_trim_d;
    end
  end

  always @(posedge clock_i) begin
    if (srst_i) begin
      c2_trim_o <= {TRIM_W{1'b0}};
    end else begin
      c2_trim_o <= c2_trim_d;
    end
  end

  // select inputs are levels from the sampling sequencer;
  // they may change every cycle and need no qualification here

  // calibration inputs are levels too; the status word
  // shows their live state, the sticky bits their history

  // no access is ever stalled: rdata_o answers exactly
  // one cycle after rd_i, whatever the calibration state

endmodule // cotr_regs

//--- dv/cotr_monitor.sv
// Purpose: trim bank checker
// Assumes: bound to cotr_regs
// Notes:   select held a cycle after writes
`timescale 1ns/1ps
`include "cotr_consts.vh"
module cotr_monitor #(parameter NUM_REGS = 5) (
  input wire clock_i, srst_i, wr_i, rd_i, c0_sel_in2_i, c1_sel_in2_i, // control
  input wire [11:0] addr_i, c0_trim_o, c1_trim_o, c2_trim_o,        // addr, trims
  input wire [15:0] wdata_i, rdata_o,                                 // data
  input wire [NUM_REGS*12-1:0] factory_trim_i                         // factory trims
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (srst_i);
  a_core0_first: assert property (wr_i && addr_i == `COTR_OFS_C0_IN1 ##1 !c0_sel_in2_i
    |=> c0_trim_o == $past(wdata_i[11:0], 2)) else $error("c0 first trim");
  a_core0_second: assert property (wr_i && addr_i == `COTR_OFS_C0_IN2 ##1 c0_sel_in2_i
    |=> c0_trim_o == $past(wdata_i[11:0], 2)) else $error("c0 second trim");
  a_core1_first: assert property (wr_i && addr_i == `COTR_OFS_C1_IN1 ##1 !c1_sel_in2_i
    |=> c1_trim_o == $past(wdata_i[11:0], 2)) else $error("c1 first trim");
  a_core1_second: assert property (wr_i && addr_i == `COTR_OFS_C1_IN2 ##1 c1_sel_in2_i
    |=> c1_trim_o == $past(wdata_i[11:0], 2)) else $error("c1 second trim");
  a_core2_first: assert property (wr_i && addr_i == `COTR_OFS_C2_IN1
    |=> ##1 c2_trim_o == $past(wdata_i[11:0], 2)) else $error("c2 trim");
  a_upper_zero: assert property (rd_i && addr_i >= 12'h08A && addr_i <= 12'h092
    |=> rdata_o[15:12] == 4'h0) else $error("upper bits");
  a_reset_trim: assert property ($fell(srst_i)
    |=> c2_trim_o == factory_trim_i[59:48]) else $error("factory trim");
  c_write: cover property (wr_i);
  c_read: cover property (rd_i);
  c_second: cover property (c0_sel_in2_i && c1_sel_in2_i);
endmodule // cotr_monitor
bind cotr_regs cotr_monitor #(.NUM_REGS(NUM_REGS)) i_mon (.clock_i, .srst_i, .wr_i, .rd_i,
  .c0_sel_in2_i, .c1_sel_in2_i, .addr_i, .c0_trim_o, .c1_trim_o, .c2_trim_o, .wdata_i,
  .rdata_o, .factory_trim_i);

//--- dv/cotr_regs_tb_top.sv
// Purpose: trim bank bench
// Assumes: read data one cycle after rd_i
// Notes:   factory trims arbitrary
`timescale 1ns/1ps
`include "cotr_consts.vh"
module cotr_regs_tb_top;
  reg clock_i = 1'b0, srst_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0, c0_sel_in2_i = 1'b0, c1_sel_in2_i = 1'b0;
  reg [11:0] addr_i = 12'h000;
  reg [15:0] wdata_i = 16'h0000;
  reg [5:0] cal = 6'h00;
  wire [15:0] rdata_o;
  wire [11:0] c0_trim_o, c1_trim_o, c2_trim_o;
  localparam [59:0] F = 60'h5A5_4B4_3C3_2D2_1E1;
  integer bad_count = 0, n_tests = 0, cyc = 0, p, i;
  cotr_regs i_dut (.*, .factory_trim_i(F), .fg_cal_running_i(cal[0]), .bg_cal_en_i(cal[1]),
    .bg_os_cal_en_i(cal[2]), .os_cal_en_i(cal[3]), .foreground_done_flag_i(cal[4]), .calibration_stopped_flag_i(cal[5]));
  always #4 clock_i = ~clock_i;
  task chk(input [15:0] s, input [15:0] e);
    n_tests = n_tests + 1;
    if (s !== e) begin
      bad_count = bad_count + 1;
      $display("unexpected at %0t: got %h want %h", $time, s, e);
    end
  endtask
  task wr(input [11:0] a, input [15:0] d);
    @(posedge clock_i) {wr_i, addr_i, wdata_i} <= {1'b1, a, d};
    @(posedge clock_i) wr_i <= 1'b0;
  endtask
  task rd(input [11:0] a, input [15:0] e);
    @(posedge clock_i) {rd_i, addr_i} <= {1'b1, a};
    @(posedge clock_i) rd_i <= 1'b0;
    #1 chk(rdata_o, e);
    @(posedge clock_i) #1 chk(rdata_o, 16'h0000);
  endtask
  task sel(input v);
    @(posedge clock_i) {c0_sel_in2_i, c1_sel_in2_i} <= {v, v};
  endtask
  task ck3(input v, input [11:0] e0, input [11:0] e1, input [11:0] e2);
    sel(v);
    repeat (2) @(posedge clock_i);
    #1 chk({4'h0, c0_trim_o}, {4'h0, e0});
    chk({4'h0, c1_trim_o}, {4'h0, e1});
    chk({4'h0, c2_trim_o}, {4'h0, e2});
  endtask
  task conclude;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  always @(posedge clock_i) begin
    cyc = cyc + 1;
    if (cyc == 2000) begin
      bad_count = bad_count + 1;
      conclude;
    end
  end
  initial begin
    repeat (8) @(posedge clock_i);
    srst_i <= 1'b0;
    for (p = 0; p < 2; p = p + 1) begin
      ck3(p[0], F[12*p +: 12], F[24+12*p +: 12], F[59:48]);
      for (i = 0; i < 5; i = i + 1) rd(12'h08A + 2*i, {4'h0, F[12*i +: 12]});
    end
    for (p = 0; p < 2; p = p + 1) begin
      sel(p[0]);
      for (i = 0; i < 5; i = i + 1) wr(12'h08A + 2*i, 16'h0100 + 16*p + i);
      ck3(p[0], 12'h100 + 17*p, 12'h102 + 17*p, 12'h104 + 16*p);
      for (i = 0; i < 5; i = i + 1) rd(12'h08A + 2*i, 16'h0100 + 16*p + i);
    end
    @(posedge clock_i) cal <= 6'h01;
    wr(`COTR_OFS_C0_IN1, 16'h0123);
    rd(`COTR_OFS_STATUS, 16'h0007);
    @(posedge clock_i) cal <= 6'h06;
    rd(`COTR_OFS_STATUS, 16'h0005);
    rd(`COTR_OFS_C0_IN1, 16'h0123);
    rd(`COTR_OFS_STATUS, 16'h000D);
    @(posedge clock_i) cal <= 6'h08;
    rd(`COTR_OFS_STATUS, 16'h000C);
    wr(`COTR_OFS_STATUS, 16'h000C);
    @(posedge clock_i) cal <= 6'h18;
    rd(`COTR_OFS_STATUS, 16'h0002);
    rd(`COTR_OFS_C0_IN1, 16'h0123);
    rd(12'h0A2, 16'h0000);
    conclude;
  end
endmodule // cotr_regs_tb_top
